// ==== tb/dsw_host_model.sv ====
/*
 Host model that drives the three pins of the DAC write port.
 Assumes a free-running system clock; pins change on its falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module dsw_host_model (
   input  wire logic clk_i,
   output var  logic sync_n_o,
   output var  logic sclk_o,
   output var  logic din_o
);
   // shift clock idles high so the first fall carries the first bit
   initial begin
      sync_n_o = 1'b1;
      sclk_o   = 1'b1;
      din_o    = 1'b0;
   end
   // wait n falling edges of the system clock
   task automatic gap(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // one frame msb first; n below 24 cuts it short by raising sync
   task automatic frame(input logic [23:0] w, input int n, input bit stay_low);
      int i;
      sync_n_o = 1'b1; // a sync left resting low is raised first
      gap(3); // 60 ns high, above the 33 ns floor
      sync_n_o = 1'b0; // falling sync arms the frame
      gap(4);
      for (i = 23; i > 23 - n; i--) begin
         din_o = w[i]; // ignored, mode, data bits, msb first
         gap(4); // 160 ns period, far below 30 MHz
         sclk_o = 1'b0;
         gap(4);
         sclk_o = 1'b1;
      end
      din_o = ~din_o; // released line must not hold a stale bit
      if (!stay_low) begin
         sync_n_o = 1'b1; // early rise aborts, late rise ends cleanly
      end
   endtask
   // stray shift-clock falls while sync is still low
   task automatic stray(input int k);
      repeat (k) begin
         sclk_o = 1'b0;
         gap(4);
         sclk_o = 1'b1;
         gap(4);
      end
   endtask
endmodule // dsw_host_model
`default_nettype wire

// ==== tb/testbench.sv ====
/*
 Self-checking bench for the 16-bit and 12-bit DAC write port builds with a host model.
 Assumes the design package and port module are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import dsw_pkg::*;
   logic        clk;
   logic        rst;
   logic        sync_n;
   logic        sclk;
   logic        din;
   logic [15:0] code;
   logic [1:0]  mode;
   logic        pd;
   logic        load;
   logic        abort;
   logic [11:0] code12;
   logic [1:0]  mode12;
   logic        pd12;
   int          n_fail = 0;
   int          samples_checked = 0;
   int          n_load = 0;
   int          n_abort = 0;
   int          cyc = 0;
   dsw_host_model host (.clk_i(clk), .sync_n_o(sync_n), .sclk_o(sclk), .din_o(din));
   dsw_port #(.RES(DSW_RES_16)) dut (
      .CLK_SYS_I(clk), .RST_I(rst), .SYNC_N_I(sync_n), .SCLK_I(sclk), .DIN_I(din),
      .DAC_CODE_O(code), .MODE_O(mode), .POWER_DOWN_O(pd), .LOAD_O(load),
      .ABORT_O(abort));
   // short-frame build on the same pins checks the parameter choice
   dsw_port #(.RES(DSW_RES_12)) dut12 (
      .CLK_SYS_I(clk), .RST_I(rst), .SYNC_N_I(sync_n), .SCLK_I(sclk), .DIN_I(din),
      .DAC_CODE_O(code12), .MODE_O(mode12), .POWER_DOWN_O(pd12), .LOAD_O(),
      .ABORT_O());
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // pulse counters catch pulses that land inside host tasks
   // sampled on the falling edge, where the one-cycle pulses have settled
   always @(negedge clk) begin
      cyc++;
      if (load === 1'b1) n_load++;
      if (abort === 1'b1) n_abort++;
      if (cyc == 8000) begin
         n_fail++;
         stop_test();
      end
   end
   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // full frame; ignored bits are nonzero so a leak into the code shows
   task automatic t_write(input logic [1:0] m, input logic [15:0] c, input bit low);
      int l0;
      int a0;
      l0 = n_load;
      a0 = n_abort;
      host.frame({6'h2a, m, c}, 24, low);
      host.gap(8);
      chk(n_load == l0 + 1 && n_abort == a0, "no single load pulse");
      chk(code === c, "code mismatch");
      chk(mode === m && pd === (m != 2'h0), "mode mismatch");
   endtask
   // frame cut short after n bits leaves code and mode alone
   task automatic t_abort(input int n);
      int l0;
      int a0;
      logic [15:0] c0;
      logic [1:0]  m0;
      l0 = n_load;
      a0 = n_abort;
      c0 = code;
      m0 = mode;
      host.frame({6'h15, 2'h3, 16'h1234}, n, 1'b0);
      host.gap(8);
      chk(n_abort == a0 + 1 && n_load == l0, "abort not flagged");
      chk(code === c0 && mode === m0, "aborted frame changed state");
   endtask
   // 16-edge frame: short build loads it, long build discards it
   task automatic t_short(input logic [1:0] m, input logic [13:0] d);
      int l0;
      int a0;
      logic [15:0] c0;
      l0 = n_load;
      a0 = n_abort;
      c0 = code;
      host.frame({m, d, 8'h00}, 16, 1'b0);
      host.gap(8);
      chk(code12 === d[13:2] && mode12 === m && pd12 === (m != 2'h0), "short load");
      chk(n_abort == a0 + 1 && n_load == l0 && code === c0, "long build kept");
   endtask
   // edges after a complete frame with sync held low are ignored
   task automatic t_stray();
      int l0;
      t_write(2'h0, 16'h5a3c, 1'b1);
      l0 = n_load;
      host.stray(3);
      host.gap(8);
      chk(n_load == l0 && code === 16'h5a3c, "stray edges took effect");
      t_write(2'h0, 16'hc3a5, 1'b0);
   endtask
   initial begin
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      chk(code === 16'h0 && mode === 2'h0 && pd === 1'b0, "reset state");
      chk(code12 === 12'h0 && mode12 === 2'h0 && pd12 === 1'b0, "short reset");
      t_write(2'h0, 16'hffff, 1'b0);
      for (int m = 1; m < 4; m++) t_write(m[1:0], 16'hffff, 1'b0);
      t_write(2'h0, 16'h0000, 1'b0);
      t_abort(1);
      t_abort(23);
      t_stray();
      t_short(2'h2, 14'h2d6b);
      t_short(2'h0, 14'h3ffc);
      stop_test();
   end
endmodule // testbench
`default_nettype wire

// ==== verilog/dsw_pkg.sv ====
/*
 Constants and carrier types for the serial write port of a single-channel
 voltage DAC. Assumes one system clock at 50 MHz that oversamples the pins.
*/
// How it works
// R01 - sync falling edge arms a new frame
// R02 - sample data on each falling shift-clock edge
// R03 - last edge executes code and mode update
// R04 - sync may stay low or rise afterwards
// R05 - host keeps sync high 33 ns before frame
// R06 - host may idle sync low between writes
// R07 - host keeps shift clock at most 30 MHz
// R08 - code is straight unsigned binary
// R09 - code range follows variant resolution
// R10 - zero code lowest, all ones full scale
// R11 - early sync rise discards the frame
// R12 - frame holds ignored, mode, data bits
// R13 - mode 00 normal, others power-down loads
// R14 - power-up code zero or midscale until write
// R15 - bits arrive most significant first
// R16 - parameter picks resolution and frame length
package dsw_pkg;
   // resolution choices
   localparam int unsigned DSW_RES_12       = 12;
   localparam int unsigned DSW_RES_14       = 14;
   localparam int unsigned DSW_RES_16       = 16;
   // frame lengths in falling edges
   localparam int unsigned DSW_FRAME_SHORT  = 16;
   localparam int unsigned DSW_FRAME_LONG   = 24;
   localparam int unsigned DSW_MODE_W       = 2;
   // top bit of the mode field in long and short frames
   localparam int unsigned DSW_MODE_BIT_HI_LONG_FRAME  = 17;
   localparam int unsigned DSW_MODE_BIT_HI_SHORT_FRAME = 15;
   localparam int unsigned DSW_CNT_W        = 5;
   // timing: system clock and host figures
   localparam int unsigned DSW_CLK_HZ       = 50_000_000;
   localparam int unsigned DSW_SYNC_HI_NS   = 33;
   localparam int unsigned DSW_SCLK_MAX_HZ  = 30_000_000;
   // least sync high time in system cycles, rounded up, at least one
   localparam int unsigned DSW_SYNC_HI_CYC  =
      ((DSW_SYNC_HI_NS * (DSW_CLK_HZ / 1_000_000)) + 999) / 1000;
   // mode encodings
   typedef enum logic [1:0] {
      DSW_MODE_NORMAL = 2'h0,
      DSW_MODE_PD_1K  = 2'h1,
      DSW_MODE_PD_100K = 2'h2,
      DSW_MODE_PD_TRI = 2'h3
   } dsw_mode_t;
   // synchronised pin group
   typedef struct packed {
      logic sync_n;
      logic sclk;
      logic din;
   } dsw_pins_t;
endpackage : dsw_pkg

// ==== verilog/dsw_port.sv ====
/*
 Serial write port of a single-channel voltage DAC: frame sync, shift clock
 and data are oversampled by the system clock; a complete frame loads the
 DAC code and the operating mode. Assumes the shift clock stays well below
 the sampling rate so each level lasts at least two system cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module dsw_port
   import dsw_pkg::*;
#(
   parameter int unsigned RES       = DSW_RES_16,              // [R16]
   parameter logic        MIDSCALE  = 1'b0,
   parameter int unsigned FRAME_LEN = (RES == DSW_RES_16) ? DSW_FRAME_LONG
                                                          : DSW_FRAME_SHORT
) (
   input  wire logic             CLK_SYS_I,
   input  wire logic             RST_I,
   input  wire logic             SYNC_N_I,
   input  wire logic             SCLK_I,
   input  wire logic             DIN_I,
   output var  logic [RES-1:0]   DAC_CODE_O,
   output var  logic [1:0]       MODE_O,
   output var  logic             POWER_DOWN_O,
   output var  logic             LOAD_O,
   output var  logic             ABORT_O
);
   localparam int unsigned SR_W = FRAME_LEN;
   localparam logic [DSW_CNT_W-1:0] LAST_CNT = DSW_CNT_W'(FRAME_LEN - 1);
   localparam int unsigned MODE_HI = (FRAME_LEN == DSW_FRAME_LONG) ? DSW_MODE_BIT_HI_LONG_FRAME
                                                                   : DSW_MODE_BIT_HI_SHORT_FRAME;
   // power-up code, zero or midscale by build
   localparam logic [RES-1:0] PWRUP_CODE = MIDSCALE ? {1'b1, {(RES-1){1'b0}}} : '0;
   localparam int unsigned DATA_W  = MODE_HI - 1;

   typedef enum logic [2:0] {
      DSW_ST_IDLE  = 3'h1,
      DSW_ST_SHIFT = 3'h2,
      DSW_ST_DONE  = 3'h4
   } dsw_state_t;

   dsw_pins_t            pins;
   logic                 sclk_d1_q;
   logic                 sync_d1_q;
   logic                 sclk_fall;
   logic                 sync_fall;
   logic                 sync_rise;
   dsw_state_t           state_q;
   logic [SR_W-1:0]      shreg_q;
   logic [SR_W-1:0]      shreg_d;
   logic [DSW_CNT_W-1:0] cnt_q;
   logic                 last_edge;

   // pins pass two flops before anything reads them
   dsw_sync2 #(.RST_VAL(1'b1)) u_sync_sync (
      .clk_i (CLK_SYS_I), .rst_i (RST_I), .d_i (SYNC_N_I), .q_o (pins.sync_n));
   dsw_sync2 #(.RST_VAL(1'b0)) u_sync_sclk (
      .clk_i (CLK_SYS_I), .rst_i (RST_I), .d_i (SCLK_I), .q_o (pins.sclk));
   dsw_sync2 #(.RST_VAL(1'b0)) u_sync_din (
      .clk_i (CLK_SYS_I), .rst_i (RST_I), .d_i (DIN_I), .q_o (pins.din));

   // edge history of the synchronised pins
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         sclk_d1_q <= 1'b0;
         sync_d1_q <= 1'b1;
      end else begin
         sclk_d1_q <= pins.sclk;
         sync_d1_q <= pins.sync_n;
      end
   end

   assign sclk_fall = sclk_d1_q & ~pins.sclk;
   assign sync_fall = sync_d1_q & ~pins.sync_n;                // [R01]
   assign sync_rise = ~sync_d1_q & pins.sync_n;
   // edges only count while sync is low
   assign last_edge = (state_q == DSW_ST_SHIFT) && sclk_fall && !pins.sync_n
                      && (cnt_q == LAST_CNT);                  // [R03]
   // data enters at bit 0 so the first bit ends at the top
   assign shreg_d   = {shreg_q[SR_W-2:0], pins.din};           // [R15]

   // frame sequencer: idle, shifting, done-wait for next sync high
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         state_q <= DSW_ST_IDLE;
         cnt_q   <= '0;
         shreg_q <= '0;
      end else begin
         case (state_q)
            DSW_ST_IDLE: begin
               if (sync_fall) begin                            // [R01]
                  state_q <= DSW_ST_SHIFT;
                  cnt_q   <= '0;
                  shreg_q <= '0;
               end
            end
            DSW_ST_SHIFT: begin
               if (pins.sync_n) begin                          // [R11]
                  state_q <= DSW_ST_IDLE;
                  cnt_q   <= '0;
                  shreg_q <= '0;
               end else if (sclk_fall) begin                   // [R02]
                  shreg_q <= shreg_d;
                  cnt_q   <= cnt_q + DSW_CNT_W'(1);
                  if (last_edge) begin
                     state_q <= DSW_ST_DONE;
                  end
               end
            end
            DSW_ST_DONE: begin
               // further edges ignored until sync rises and falls again
               if (pins.sync_n) begin                          // [R04]
                  state_q <= DSW_ST_IDLE;
                  cnt_q   <= '0;
               end
            end
            default: begin
               state_q <= DSW_ST_IDLE;
            end
         endcase
      end
   end

   // output register: power-up value holds until the first full frame
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         DAC_CODE_O   <= PWRUP_CODE;                                // [R14]
         MODE_O       <= DSW_MODE_NORMAL;
         POWER_DOWN_O <= 1'b0;
      end else if (last_edge) begin
         // code kept as straight binary; mode bits sit above the data
         // all zeros is the bottom of the range, all ones the top of the range
         DAC_CODE_O   <= shreg_d[DATA_W-1 -: RES];                  // [R08] [R09] [R10] [R12]
         MODE_O       <= shreg_d[MODE_HI -: DSW_MODE_W];            // [R13]
         POWER_DOWN_O <= |shreg_d[MODE_HI -: DSW_MODE_W];           // [R13]
      end
   end

   // one-cycle status pulses for completed and discarded frames
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         LOAD_O  <= 1'b0;
         ABORT_O <= 1'b0;
      end else begin
         LOAD_O  <= last_edge;
         ABORT_O <= (state_q == DSW_ST_SHIFT) && sync_rise;         // [R11]
      end
   end

   // a completed frame loads exactly the sampled word
   a_load_value: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R03]
      last_edge |=> (LOAD_O && DAC_CODE_O == $past(shreg_d[DATA_W-1 -: RES])))
      else $error("code not loaded on last edge");
   // an aborted frame leaves code and mode untouched
   a_abort_hold: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R11]
      ((state_q == DSW_ST_SHIFT) && pins.sync_n) |=>
         ($stable(DAC_CODE_O) && $stable(MODE_O) && state_q == DSW_ST_IDLE))
      else $error("aborted frame changed outputs");
   // the code changes only with a load pulse
   a_code_cause: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R14]
      !$stable(DAC_CODE_O) |-> LOAD_O)
      else $error("code changed without a frame");
   // power-down flag tracks mode
   a_pd_mode: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R13]
      POWER_DOWN_O == (MODE_O != DSW_MODE_NORMAL))
      else $error("power-down flag disagrees with mode");
   // a frame starts only on a sync fall
   a_frame_start: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R01]
      (state_q == DSW_ST_IDLE && !sync_fall) |=> state_q == DSW_ST_IDLE)
      else $error("frame started without sync fall");
   // each sampled edge advances the count by one
   a_edge_count: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R02]
      (state_q == DSW_ST_SHIFT && sclk_fall && !pins.sync_n) |=>
         (cnt_q == $past(cnt_q) + DSW_CNT_W'(1) || state_q == DSW_ST_DONE))
      else $error("edge count did not advance");
   // after completion edges are ignored until sync rises
   a_done_hold: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R04]
      (state_q == DSW_ST_DONE && !pins.sync_n) |=> (state_q == DSW_ST_DONE && !LOAD_O))
      else $error("done state left while sync low");
   // bottom shift bit is the bit just sampled
   a_msb_first: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R15]
      (state_q == DSW_ST_SHIFT && sclk_fall && !pins.sync_n) |=>
         shreg_q[0] == $past(pins.din))
      else $error("shift direction wrong");
   // older bits move up one place on every sampled edge
   a_shift_up: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R15]
      (state_q == DSW_ST_SHIFT && sclk_fall && !pins.sync_n) |=>
         shreg_q[SR_W-1:1] == $past(shreg_q[SR_W-2:0]))
      else $error("shift register did not move up");
   // first sample after reset release still shows the power-up values
   a_reset_values: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R14]
      $fell(RST_I) |-> (DAC_CODE_O == PWRUP_CODE && MODE_O == DSW_MODE_NORMAL
                        && !LOAD_O && !ABORT_O))
      else $error("outputs left power-up values early");
   // a discarded frame raises the abort pulse and never the load pulse
   a_abort_pulse: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R11]
      ((state_q == DSW_ST_SHIFT) && pins.sync_n) |=> (ABORT_O && !LOAD_O))
      else $error("discarded frame not flagged");
   // load and abort never flag the same frame
   a_pulse_excl: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R11]
      !(LOAD_O && ABORT_O))
      else $error("load and abort together");
   // the mode field lands with the code on the last edge
   a_mode_load: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R12]
      last_edge |=> (MODE_O == $past(shreg_d[MODE_HI -: DSW_MODE_W])
                     && POWER_DOWN_O == $past(|shreg_d[MODE_HI -: DSW_MODE_W])))
      else $error("mode not loaded on last edge");
   // the load pulse only follows the final counted edge
   a_load_count: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R03]
      LOAD_O |-> (state_q == DSW_ST_DONE && cnt_q == DSW_CNT_W'(FRAME_LEN)))
      else $error("load without a full frame");
   // the edge count never runs past one frame
   a_count_bound: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R16]
      cnt_q <= DSW_CNT_W'(FRAME_LEN))
      else $error("edge count past frame length");
   // a sync fall while idle clears the count and the shift register
   a_frame_arm: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R01]
      (state_q == DSW_ST_IDLE && sync_fall) |=>
         (state_q == DSW_ST_SHIFT && cnt_q == '0 && shreg_q == '0))
      else $error("frame not armed on sync fall");
   // a sync rise after completion frees the port for the next frame
   a_done_idle: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R04]
      (state_q == DSW_ST_DONE && pins.sync_n) |=> state_q == DSW_ST_IDLE)
      else $error("done state kept after sync rise");
endmodule // dsw_port
`default_nettype wire

// ==== verilog/dsw_sync2.sv ====
/*
 Two-flop synchroniser for one asynchronous pin.
 Assumes the input is from outside the system clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module dsw_sync2 #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic d_i,
   output var  logic q_o
);
   logic meta_q;
   // first flop feeds only the second flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= RST_VAL;
         q_o    <= RST_VAL;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule // dsw_sync2
`default_nettype wire
